// >>> hdl/mie_pkg.sv
/*
  constants for the indirect extended-register portal: portal offsets,
  control field layout, device and register numbers, reset values.
  assumes a 16-bit management register space reached by a 5-bit address.
*/
package mie_pkg;

    // ==========================================================
    // portal registers in the basic management space
    localparam logic [4:0]  MIE_CTRL_PORT_ADDR = 5'h0d;
    localparam logic [4:0]  MIE_DATA_PORT_ADDR = 5'h0e;

    // ==========================================================
    // control port fields
    localparam int          MIE_OP_HI          = 15;
    localparam int          MIE_OP_LO          = 14;
    localparam int          MIE_DEV_HI         = 4;
    localparam int          MIE_DEV_LO         = 0;

    typedef enum logic [1:0] {
        MIE_OP_ADDR     = 2'h0,
        MIE_OP_DATA     = 2'h1,
        MIE_OP_DATA_INC = 2'h2,
        MIE_OP_DATA_WRI = 2'h3
    } mie_op_t;

    // ==========================================================
    // indirect devices and registers
    localparam logic [4:0]  MIE_DEV_PMA        = 5'h01;
    localparam logic [4:0]  MIE_DEV_PCS        = 5'h03;
    localparam logic [4:0]  MIE_DEV_AN         = 5'h07;
    localparam logic [4:0]  MIE_DEV_WAKE       = 5'h1f;
    localparam logic [15:0] MIE_REG_PMA_CTRL   = 16'h0000;
    localparam logic [15:0] MIE_REG_PMA_STAT   = 16'h0001;
    localparam logic [15:0] MIE_REG_PCS_CTRL   = 16'h0000;
    localparam logic [15:0] MIE_REG_EEE_ADV    = 16'h003c;
    localparam logic [15:0] MIE_REG_WAKE_CTRL  = 16'h0000;
    localparam logic [15:0] MIE_REG_WAKE_MAC0  = 16'h0019;
    localparam int          MIE_WAKE_MAC_WORDS = 3;

    // ==========================================================
    // bit positions
    localparam int          MIE_BIT_LPI_EN     = 12;
    localparam int          MIE_BIT_IDLE_LATCH = 8;
    localparam int          MIE_BIT_IDLE_LIVE  = 3;
    localparam int          MIE_BIT_RXC_STOP   = 10;
    localparam int          MIE_BIT_EEE_GIG    = 2;
    localparam int          MIE_BIT_EEE_100    = 1;

    // ==========================================================
    // reset values and writable masks
    localparam logic [15:0] MIE_PMA_CTRL_RST   = 16'h0000;
    localparam logic [15:0] MIE_PCS_CTRL_RST   = 16'h0c10;
    localparam logic [15:0] MIE_PCS_CTRL_WMASK = 16'h0ff3;
    localparam logic [15:0] MIE_EEE_ADV_RST    = 16'h0000;
    localparam logic [15:0] MIE_EEE_ADV_WMASK  = 16'h0002;
    localparam logic [15:0] MIE_WAKE_CTRL_RST  = 16'h0000;
    localparam logic [15:0] MIE_WAKE_CTRL_WMASK = 16'hc07f;
    localparam logic [15:0] MIE_ZERO16         = 16'h0000;
    localparam logic [15:0] MIE_ONE16          = 16'h0001;

endpackage

// >>> hdl/mie_sync.sv
/*
  three-stage synchroniser with agreement filter.
  assumes the input is a slow level from outside the mclk domain.
*/
`timescale 1ns/1ps
module mie_sync
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // level in and filtered level out
    input  wire logic async_in,
    output logic      level_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ==========================================================
    // chain: first stage is read only by the second
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once the last two stages agree
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            level_out <= 1'b0;
        else if (s2_q == s3_q)
            level_out <= s3_q;
    end

endmodule

// >>> hdl/mie_wake_store.sv
/*
  wake-up station address words of the wake device, kept in a small array.
  assumes the caller decodes the device and gives a register number.
*/
`timescale 1ns/1ps
module mie_wake_store
    import mie_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // access
    input  wire logic [15:0] reg_num,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // lookup
    output logic             hit,
    output logic [15:0]      rd_data
);

    logic [15:0] mac_q [MIE_WAKE_MAC_WORDS];
    logic [15:0] idx;

    assign idx = reg_num - MIE_REG_WAKE_MAC0;
    assign hit = (reg_num >= MIE_REG_WAKE_MAC0) && (idx < 16'(MIE_WAKE_MAC_WORDS));

    // ==========================================================
    // station address words, writable by software
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < MIE_WAKE_MAC_WORDS; i++)
                mac_q[i] <= MIE_ZERO16;
        end
        else if (wr_en && hit)
            mac_q[idx[1:0]] <= wr_data;
    end

    // read mux; zero outside the window
    always_comb
    begin
        rd_data = MIE_ZERO16;
        if (hit)
            rd_data = mac_q[idx[1:0]];
    end

endmodule

// >>> hdl/mie_regs.sv
/*
  indirect extended-register portal with the energy-efficient idle registers.
  assumes a management controller gives one-cycle read and write strobes
  on mclk with a 5-bit basic register address; idle status comes from
  the receive datapath on another clock and is synchronised here.
*/
// Functional notes
// - control write with code 00 and a device makes the next data write a register number.
// - in address mode a data port write loads the register number for the device.
// - control write with code 01 selects data access without changing the number.
// - in data mode a data port write stores into the selected indirect register.
// - code 10 returns the selected register on each read and then advances the number.
// - the wake device holds a three-word station address readable by sequential reads.
// - the idle-entered status bit latches high on idle entry and holds until read.
// - the idle live bit is read-only and shows the current idle state.
// - the receive clock stop permission bit resets to one and steers the clock stop output.
// - the gigabit capability bit is read-only and always zero.
// - the 100 Mb/s capability bit is writable and resets to zero.
// - the control op field decodes to address, data, increment on both, increment on writes.
// - the low five control bits select the indirect device for later accesses.
`timescale 1ns/1ps
module mie_regs
    import mie_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // basic register access
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic        mgmt_wr,
    input  wire logic        mgmt_rd,
    input  wire logic [15:0] mgmt_wdata,
    output logic [15:0]      mgmt_rdata,
    output logic             mgmt_hit,
    // idle status from the datapath
    input  wire logic        idle_live_raw,
    // controls to the datapath
    output logic             lpi_enable,
    output logic             rx_clock_stop_allow,
    output logic             eee_100_advertise,
    output logic [15:0]      wake_control
);
    import mie_pkg::*;

    logic [1:0]  indirect_op_code_q;
    logic [4:0]  indirect_device_select_q;
    logic [15:0] reg_num_q;
    logic [15:0] pma_control_one_q;
    logic [15:0] pcs_eee_control_one_q;
    logic [15:0] eee_advertise_q;
    logic [15:0] wake_ctrl_q;
    logic        idle_entered_latch_q;
    logic        idle_live_state;
    logic        idle_live_d1_q;
    logic        ctrl_wr;
    logic        data_wr;
    logic        data_rd;
    logic        data_mode;
    logic        ind_wr;
    logic        wake_hit;
    logic [15:0] wake_rdata;
    logic [15:0] ind_rdata;
    logic [15:0] pma_status_one;
    logic        stat_read;
    logic        idle_rise;

    // ==========================================================
    // helpers
    function automatic logic sel(input logic [4:0] dev, input logic [15:0] num,
                                 input logic [4:0] want_dev, input logic [15:0] want_num);
        sel = (dev == want_dev) && (num == want_num);
    endfunction

    function automatic logic [15:0] mwrite(input logic [15:0] old, input logic [15:0] nv,
                                           input logic [15:0] mask);
        mwrite = (old & ~mask) | (nv & mask);
    endfunction

    // ==========================================================
    // strobes
    assign ctrl_wr   = mgmt_wr && (mgmt_addr == MIE_CTRL_PORT_ADDR);
    assign data_wr   = mgmt_wr && (mgmt_addr == MIE_DATA_PORT_ADDR);
    assign data_rd   = mgmt_rd && (mgmt_addr == MIE_DATA_PORT_ADDR);
    assign data_mode = (indirect_op_code_q != MIE_OP_ADDR);
    assign ind_wr    = data_wr && data_mode;
    assign mgmt_hit  = (mgmt_addr == MIE_CTRL_PORT_ADDR) || (mgmt_addr == MIE_DATA_PORT_ADDR);

    // ==========================================================
    // control port: op code and device select
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            indirect_op_code_q       <= MIE_OP_ADDR;
            indirect_device_select_q <= 5'h00;
        end
        else if (ctrl_wr)
        begin
            indirect_op_code_q       <= mgmt_wdata[MIE_OP_HI:MIE_OP_LO];
            indirect_device_select_q <= mgmt_wdata[MIE_DEV_HI:MIE_DEV_LO];
        end
    end

    // ==========================================================
    // register number: load in address mode, post increment per op code
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            reg_num_q <= MIE_ZERO16;
        else if (data_wr && !data_mode)
            reg_num_q <= mgmt_wdata;
        else if (data_wr && indirect_op_code_q[1])
            reg_num_q <= reg_num_q + MIE_ONE16;
        else if (data_rd && (indirect_op_code_q == MIE_OP_DATA_INC))
            reg_num_q <= reg_num_q + MIE_ONE16;
    end

    // ==========================================================
    // pma control: whole word writable
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            pma_control_one_q <= MIE_PMA_CTRL_RST;
        else if (ind_wr && sel(indirect_device_select_q, reg_num_q, MIE_DEV_PMA, MIE_REG_PMA_CTRL))
            pma_control_one_q <= mgmt_wdata;
    end

    // pcs control: read-only bits 15:12 and 3:2 keep their reset value
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            pcs_eee_control_one_q <= MIE_PCS_CTRL_RST;
        else if (ind_wr && sel(indirect_device_select_q, reg_num_q, MIE_DEV_PCS, MIE_REG_PCS_CTRL))
            pcs_eee_control_one_q <= mwrite(pcs_eee_control_one_q, mgmt_wdata, MIE_PCS_CTRL_WMASK);
    end

    // advertisement: only the 100 Mb/s bit can change
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            eee_advertise_q <= MIE_EEE_ADV_RST;
        else if (ind_wr && sel(indirect_device_select_q, reg_num_q, MIE_DEV_AN, MIE_REG_EEE_ADV))
            eee_advertise_q <= mwrite(eee_advertise_q, mgmt_wdata, MIE_EEE_ADV_WMASK);
    end

    // wake control
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            wake_ctrl_q <= MIE_WAKE_CTRL_RST;
        else if (ind_wr && sel(indirect_device_select_q, reg_num_q, MIE_DEV_WAKE, MIE_REG_WAKE_CTRL))
            wake_ctrl_q <= mwrite(wake_ctrl_q, mgmt_wdata, MIE_WAKE_CTRL_WMASK);
    end

    // station address words live in their own store
    mie_wake_store u_wake
    (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .reg_num (reg_num_q),
        .wr_en   (ind_wr && (indirect_device_select_q == MIE_DEV_WAKE)),
        .wr_data (mgmt_wdata),
        .hit     (wake_hit),
        .rd_data (wake_rdata)
    );

    // ==========================================================
    // idle status: synchronised, then latched on rising edge
    mie_sync u_idle_sync
    (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .async_in  (idle_live_raw),
        .level_out (idle_live_state)
    );

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            idle_live_d1_q <= 1'b0;
        else
            idle_live_d1_q <= idle_live_state;
    end

    assign idle_rise = idle_live_state && !idle_live_d1_q;
    // an address-mode read of the data port returns the number, not the status, so it must not clear
    assign stat_read = data_rd && data_mode && sel(indirect_device_select_q, reg_num_q, MIE_DEV_PMA, MIE_REG_PMA_STAT);

    // a new entry in the read cycle wins over the clear, so no event is lost
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            idle_entered_latch_q <= 1'b0;
        else if (idle_rise)
            idle_entered_latch_q <= 1'b1;
        else if (stat_read)
            idle_entered_latch_q <= 1'b0;
    end

    // ==========================================================
    // status word: reserved bits read zero
    always_comb
    begin
        pma_status_one = MIE_ZERO16;
        pma_status_one[MIE_BIT_IDLE_LATCH] = idle_entered_latch_q;
        pma_status_one[MIE_BIT_IDLE_LIVE]  = idle_live_state;
    end

    // indirect read mux; unimplemented registers read zero
    always_comb
    begin
        ind_rdata = MIE_ZERO16;
        if (sel(indirect_device_select_q, reg_num_q, MIE_DEV_PMA, MIE_REG_PMA_CTRL))
            ind_rdata = pma_control_one_q;
        else if (sel(indirect_device_select_q, reg_num_q, MIE_DEV_PMA, MIE_REG_PMA_STAT))
            ind_rdata = pma_status_one;
        else if (sel(indirect_device_select_q, reg_num_q, MIE_DEV_PCS, MIE_REG_PCS_CTRL))
            ind_rdata = pcs_eee_control_one_q;
        else if (sel(indirect_device_select_q, reg_num_q, MIE_DEV_AN, MIE_REG_EEE_ADV))
            ind_rdata = eee_advertise_q;
        else if (sel(indirect_device_select_q, reg_num_q, MIE_DEV_WAKE, MIE_REG_WAKE_CTRL))
            ind_rdata = wake_ctrl_q;
        else if ((indirect_device_select_q == MIE_DEV_WAKE) && wake_hit)
            ind_rdata = wake_rdata;
    end

    // port read data, registered on the read strobe
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            mgmt_rdata <= MIE_ZERO16;
        else if (mgmt_rd && (mgmt_addr == MIE_CTRL_PORT_ADDR))
            mgmt_rdata <= {indirect_op_code_q, 9'h000, indirect_device_select_q};
        else if (data_rd)
            mgmt_rdata <= data_mode ? ind_rdata : reg_num_q;
        else if (mgmt_rd)
            mgmt_rdata <= MIE_ZERO16;
    end

    // ==========================================================
    // controls out
    assign lpi_enable          = pma_control_one_q[MIE_BIT_LPI_EN];
    assign rx_clock_stop_allow = pcs_eee_control_one_q[MIE_BIT_RXC_STOP];
    assign eee_100_advertise   = eee_advertise_q[MIE_BIT_EEE_100];
    assign wake_control        = wake_ctrl_q;

    // ==========================================================
    // assertions
    gig_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !eee_advertise_q[MIE_BIT_EEE_GIG])
        else $error("gigabit capability bit set");
    inc_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (data_rd && indirect_op_code_q == MIE_OP_DATA_INC && !data_wr) |=> reg_num_q == $past(reg_num_q) + 16'h0001)
        else $error("post increment on read missing");
    noinc_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (data_rd && indirect_op_code_q == MIE_OP_DATA && !data_wr) |=> $stable(reg_num_q))
        else $error("number moved without increment");
    addr_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (data_wr && indirect_op_code_q == MIE_OP_ADDR) |=> reg_num_q == $past(mgmt_wdata))
        else $error("register number not loaded");
    ctrl_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ctrl_wr |=> indirect_device_select_q == $past(mgmt_wdata[4:0]) && indirect_op_code_q == $past(mgmt_wdata[15:14]))
        else $error("control port not loaded");
    latch_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (idle_entered_latch_q && !stat_read) |=> idle_entered_latch_q)
        else $error("idle latch dropped without read");
    latch_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        idle_rise |=> idle_entered_latch_q)
        else $error("idle latch not set");
    live_ro_a: assert property (@(posedge mclk) disable iff (sys_rst)
        stat_read |=> mgmt_rdata[MIE_BIT_IDLE_LIVE] == $past(idle_live_state))
        else $error("live idle bit wrong");
    inc_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (data_wr && indirect_op_code_q[1]) |=> reg_num_q == $past(reg_num_q) + 16'h0001)
        else $error("post increment on write missing");
    adv_mask_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (eee_advertise_q & ~MIE_EEE_ADV_WMASK) == 16'h0000)
        else $error("read-only advertisement bits changed");
    pcs_ro_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (pcs_eee_control_one_q & ~MIE_PCS_CTRL_WMASK) == (MIE_PCS_CTRL_RST & ~MIE_PCS_CTRL_WMASK))
        else $error("read-only pcs bits changed");
    rst_stop_a: assert property (@(posedge mclk) $past(sys_rst) |-> rx_clock_stop_allow && !eee_100_advertise)
        else $error("wrong reset value");

    inc_cov_c: cover property (@(posedge mclk) disable iff (sys_rst)
        data_rd && indirect_op_code_q == MIE_OP_DATA_INC ##2 data_rd ##2 data_rd);
    wr_cov_c: cover property (@(posedge mclk) disable iff (sys_rst) ind_wr && wake_hit);
    latch_cov_c: cover property (@(posedge mclk) disable iff (sys_rst) idle_rise && stat_read);
    adv_cov_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(eee_100_advertise));

endmodule

// >>> bench/mie_host_model.sv
/*
  management controller model: issues one-cycle write and read strobes
  on the basic register space of the portal.
  assumes registered read data one cycle after the read edge.
*/
`timescale 1ns/1ps
module mie_host_model
(
    // clock
    input  wire logic        mclk,
    // basic register access
    output logic [4:0]       mgmt_addr,
    output logic             mgmt_wr,
    output logic             mgmt_rd,
    output logic [15:0]      mgmt_wdata,
    input  wire logic [15:0] mgmt_rdata
);
    // =====================================================
    // bus idle at time zero
    initial
    begin
        mgmt_addr  = 5'h00;
        mgmt_wr    = 1'b0;
        mgmt_rd    = 1'b0;
        mgmt_wdata = 16'h0000;
    end

    // one write strobe; released lines show inverted values so stale data never looks valid
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        mgmt_addr  <= a;
        mgmt_wdata <= d;
        mgmt_wr    <= 1'b1;
        @(posedge mclk);
        mgmt_wr    <= 1'b0;
        mgmt_addr  <= ~a;
        mgmt_wdata <= ~d;
    endtask

    // address only, no strobe: lets the bench look at the port decode
    task automatic park(input logic [4:0] a);
        @(posedge mclk);
        mgmt_addr <= a;
        @(posedge mclk);
    endtask

    // one read strobe; data taken once the registered answer has landed
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk);
        mgmt_addr <= a;
        mgmt_rd   <= 1'b1;
        @(posedge mclk);
        mgmt_rd   <= 1'b0;
        mgmt_addr <= ~a;
        #1;
        d = mgmt_rdata;
    endtask
endmodule

// >>> bench/tb_mie_regs.sv
/*
  self-checking bench for the indirect register portal.
  assumes the host model drives the management side, bench drives idle.
*/
`timescale 1ns/1ps
module tb_mie_regs;
    import mie_pkg::*;
    logic        mclk;
    logic        sys_rst;
    logic        idle_live_raw;
    logic [4:0]  mgmt_addr;
    logic        mgmt_wr;
    logic        mgmt_rd;
    logic        mgmt_hit;
    logic        lpi_enable;
    logic        rx_clock_stop_allow;
    logic        eee_100_advertise;
    logic [15:0] mgmt_wdata;
    logic [15:0] mgmt_rdata;
    logic [15:0] wake_control;
    logic [15:0] rv;
    logic [15:0] w;
    logic [15:0] wexp [3];
    logic [4:0]  dv [3];
    logic [15:0] rn [3];
    logic [15:0] rs [3];
    logic [15:0] mk [3];
    logic        adv_bit   = 1'b0;
    int          err_total = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    integer      seed      = 32'h5549;

    // =====================================================
    // instances
    mie_host_model h (.mclk(mclk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
                      .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));
    mie_regs dut (.mclk(mclk), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
                  .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
                  .mgmt_hit(mgmt_hit), .idle_live_raw(idle_live_raw), .lpi_enable(lpi_enable),
                  .rx_clock_stop_allow(rx_clock_stop_allow), .eee_100_advertise(eee_100_advertise),
                  .wake_control(wake_control));

    // 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // =====================================================
    // helpers
    task automatic test_done;
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [15:0] ctl(input logic [1:0] op, input logic [4:0] dev);
        return {op, 9'h000, dev};
    endfunction

    function automatic logic [15:0] masked(input logic [15:0] r, input logic [15:0] m, input logic [15:0] d);
        return (d & m) | (r & ~m);
    endfunction

    // address phase then data-mode select
    task automatic sel(input logic [4:0] dev, input logic [15:0] num, input logic [1:0] op);
        h.wr(MIE_CTRL_PORT_ADDR, ctl(2'h0, dev));
        h.wr(MIE_DATA_PORT_ADDR, num);
        h.wr(MIE_CTRL_PORT_ADDR, ctl(op, dev));
    endtask

    task automatic mwr(input logic [4:0] dev, input logic [15:0] num, input logic [15:0] d);
        sel(dev, num, 2'h1);
        h.wr(MIE_DATA_PORT_ADDR, d);
    endtask

    task automatic mrd(input logic [4:0] dev, input logic [15:0] num, output logic [15:0] d);
        sel(dev, num, 2'h1);
        h.rd(MIE_DATA_PORT_ADDR, d);
    endtask

    // register number as seen through the data port in address mode
    task automatic num_chk(input logic [15:0] exp);
        h.wr(MIE_CTRL_PORT_ADDR, ctl(2'h0, MIE_DEV_WAKE));
        h.rd(MIE_DATA_PORT_ADDR, rv);
        chk("reg_number", rv, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // hang guard: far above the few hundred cycles the sequence needs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            test_done;
        end
    end

    // =====================================================
    // main sequence
    initial
    begin
        idle_live_raw = 1'b0;
        sys_rst       = 1'b1;
        dv = '{MIE_DEV_AN, MIE_DEV_PCS, MIE_DEV_WAKE};
        rn = '{MIE_REG_EEE_ADV, MIE_REG_PCS_CTRL, MIE_REG_WAKE_CTRL};
        rs = '{MIE_EEE_ADV_RST, MIE_PCS_CTRL_RST, MIE_WAKE_CTRL_RST};
        mk = '{MIE_EEE_ADV_WMASK, MIE_PCS_CTRL_WMASK, MIE_WAKE_CTRL_WMASK};
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("clk_stop_rst", {15'h0000, rx_clock_stop_allow}, MIE_ONE16);
        mrd(MIE_DEV_PCS, MIE_REG_PCS_CTRL, rv);
        chk("pcs_rst", rv, MIE_PCS_CTRL_RST);
        mrd(MIE_DEV_AN, MIE_REG_EEE_ADV, rv);
        chk("adv_rst", rv, MIE_ZERO16);
        // documented wake write, then repeated reads must not move the number
        mwr(MIE_DEV_WAKE, MIE_REG_WAKE_CTRL, 16'h0001);
        settle;
        chk("wake_ctl", wake_control, 16'h0001);
        h.rd(MIE_DATA_PORT_ADDR, rv);
        h.rd(MIE_DATA_PORT_ADDR, rv);
        chk("no_inc", rv, 16'h0001);
        // op 11: writes advance, reads do not
        sel(MIE_DEV_WAKE, MIE_REG_WAKE_MAC0, 2'h3);
        for (int i = 0; i < 3; i++)
        begin
            wexp[i] = 16'($random(seed));
            h.wr(MIE_DATA_PORT_ADDR, wexp[i]);
        end
        num_chk(MIE_REG_WAKE_MAC0 + 16'h0003);
        sel(MIE_DEV_WAKE, MIE_REG_WAKE_MAC0, 2'h3);
        h.rd(MIE_DATA_PORT_ADDR, rv);
        h.rd(MIE_DATA_PORT_ADDR, rv);
        chk("op11_read", rv, wexp[0]);
        // op 10: three sequential station-address reads
        sel(MIE_DEV_WAKE, MIE_REG_WAKE_MAC0, 2'h2);
        for (int i = 0; i < 3; i++)
        begin
            h.rd(MIE_DATA_PORT_ADDR, rv);
            chk("mac_word", rv, wexp[i]);
        end
        num_chk(MIE_REG_WAKE_MAC0 + 16'h0003);
        // op 10 on a write: stores the word and advances the number
        sel(MIE_DEV_WAKE, MIE_REG_WAKE_MAC0 + 16'h0001, 2'h2);
        h.wr(MIE_DATA_PORT_ADDR, ~wexp[1]);
        num_chk(MIE_REG_WAKE_MAC0 + 16'h0002);
        mrd(MIE_DEV_WAKE, MIE_REG_WAKE_MAC0 + 16'h0001, rv);
        chk("op10_write", rv, ~wexp[1]);
        // all-ones then random writes against read-only and writable bits, per device
        for (int k = 0; k < 12; k++)
        begin
            w = (k < 3) ? 16'hffff : 16'($random(seed));
            mwr(dv[k % 3], rn[k % 3], w);
            mrd(dv[k % 3], rn[k % 3], rv);
            chk("masked_rb", rv, masked(rs[k % 3], mk[k % 3], w));
            if (k % 3 == 0)
                adv_bit = w[1];
            chk("adv_out", {15'h0000, eee_100_advertise}, {15'h0000, adv_bit});
            if (k % 3 == 1)
                chk("clk_stop", {15'h0000, rx_clock_stop_allow}, {15'h0000, w[10]});
        end
        mwr(MIE_DEV_PMA, MIE_REG_PMA_CTRL, 16'h1000);
        settle;
        chk("lpi_en", {15'h0000, lpi_enable}, MIE_ONE16);
        // control port keeps op and device only
        h.wr(MIE_CTRL_PORT_ADDR, 16'hffff);
        h.rd(MIE_CTRL_PORT_ADDR, rv);
        chk("ctrl_rb", rv, 16'hc01f);
        h.rd(5'h02, rv);
        chk("basic_other", rv, MIE_ZERO16);
        h.park(MIE_DATA_PORT_ADDR);
        chk("hit_data", {15'h0000, mgmt_hit}, MIE_ONE16);
        h.park(5'h02);
        chk("hit_other", {15'h0000, mgmt_hit}, MIE_ZERO16);
        // idle entry then exit: latch holds until read, live bit follows
        @(posedge mclk);
        idle_live_raw <= 1'b1;
        repeat (10) @(posedge mclk);
        idle_live_raw <= 1'b0;
        repeat (10) @(posedge mclk);
        mrd(MIE_DEV_PMA, MIE_REG_PMA_STAT, rv);
        chk("idle_latched", rv, 16'h0100);
        mrd(MIE_DEV_PMA, MIE_REG_PMA_STAT, rv);
        chk("idle_cleared", rv, MIE_ZERO16);
        @(posedge mclk);
        idle_live_raw <= 1'b1;
        repeat (10) @(posedge mclk);
        mrd(MIE_DEV_PMA, MIE_REG_PMA_STAT, rv);
        chk("idle_live", rv, 16'h0108);
        // mid-run reset: written advertisement and clock-stop bits go back to reset values
        mwr(MIE_DEV_AN, MIE_REG_EEE_ADV, 16'h0002);
        mwr(MIE_DEV_PCS, MIE_REG_PCS_CTRL, 16'h0000);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("clk_stop_rerst", {15'h0000, rx_clock_stop_allow}, MIE_ONE16);
        mrd(MIE_DEV_AN, MIE_REG_EEE_ADV, rv);
        chk("adv_rerst", rv, MIE_EEE_ADV_RST);
        test_done;
    end
endmodule
